// *** design/_unused_guard_none.sv ***
`default_nettype none
`default_nettype wire

// *** design/gpi_cfg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface gpi_cfg_if;
   logic [12:0] enable;
   logic [12:0] polarity;
   logic [1:0] edge_sel;
   logic [12:0] event_out;
   modport ctl (output enable, output polarity, output edge_sel,
      input event_out);
   modport mon (input enable, input polarity, input edge_sel,
      output event_out);
endinterface
`default_nettype wire

// *** design/gpi_monitor_cond.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpi_monitor_cond (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // pins and configuration
   input wire logic [pm_throttle_pkg::NUM_PINS-1:0] general_input_pin,
   gpi_cfg_if.mon cfg
);
   import pm_throttle_pkg::*;

   typedef struct packed {
      logic [NUM_MON-1:0] prev;
      logic [NUM_MON-1:0] evt;
   } mon_state_type;

   mon_state_type r, n;
   logic [NUM_MON-1:0] qual;
   logic [NUM_MON-1:0] edge_mode;

   // ---------------------------------------------------------------
   // per monitor qualification
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_MON; g++) begin : g_mon
         assign qual[g] = cfg.enable[g] &
            (general_input_pin[MON_PIN_MAP[g]] ^ cfg.polarity[g]);
         if (g >= NUM_MON - NUM_EDGE) begin : g_edge
            assign edge_mode[g] =
               cfg.edge_sel[g - (NUM_MON - NUM_EDGE)];
         end else begin : g_level
            assign edge_mode[g] = 1'b0;
         end
      end
   endgenerate

   always_comb begin
      n = r;
      n.prev = qual;
      n.evt = (qual & ~r.prev & edge_mode) | (qual & ~edge_mode);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign cfg.event_out = r.evt;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   disabled_mon_a: assert property (1'b1 |=>
      (cfg.event_out & ~$past(cfg.enable)) == 13'h0000)
      else $error("disabled monitor produced an event");
   mon1_level_a: assert property (1'b1 |=> cfg.event_out[0] ==
      $past(cfg.enable[0] & (general_input_pin[5] ^ cfg.polarity[0])))
      else $error("monitor 1 level qualification wrong");
   mon13_edge_a: assert property (cfg.edge_sel[1] &&
      $past(cfg.edge_sel[1]) && cfg.event_out[12] |=> !cfg.event_out[12])
      else $error("monitor 13 edge event longer than one cycle");
   mon12_edge_a: assert property (cfg.edge_sel[0] &&
      $past(cfg.edge_sel[0]) && cfg.event_out[11] |=> !cfg.event_out[11])
      else $error("monitor 12 edge event longer than one cycle");
   edge_event_c: cover property (cfg.edge_sel[1] && cfg.event_out[12]);
endmodule // gpi_monitor_cond
`default_nettype wire

// *** design/pm_throttle_ctl.sv ***
// Behaviour
// - stop-clock asserted for the duty share of each throttle period.
// - duty codes 001..111 give 12.5% to 87.5% in 12.5% steps.
// - on processor wake, load timer with lock count in lock mode.
// - lock timing ticks each 1 ms when select is 0, 1 us when 1.
// - burst count is the initial and reload value of the burst timer.
// - monitor 13 input is level when its edge bit is 0, else edge.
// - monitor 12 input is level when its edge bit is 0, else edge.
// - polarity bit 0 means asserted high, 1 asserted low, per monitor.
// - a monitor input reaches decode logic only when its enable is set.
// - fixed pin to monitor wiring; every monitor has an input, monitor 1 takes pin 5.
// - cache sleep driven only when enabled; duty cycle shapes it while throttling, else held asserted.
`timescale 1ns/1ps
`default_nettype none
module pm_throttle_ctl #(
   parameter int unsigned MS_CYCLES = pm_throttle_pkg::MS_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [pm_throttle_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // processor clock control
   input wire logic thermal_alarm_in_n,
   input wire logic cpu_wake,
   input wire logic burst_start,
   input wire logic clock_ctl_mode,
   output logic cpu_stop_clock_n,
   output logic cache_sleep_out,
   output logic fb_expired,
   output logic pll_lock_done,
   // general purpose inputs
   input wire logic [pm_throttle_pkg::NUM_PINS-1:0] general_input_pin,
   output logic [pm_throttle_pkg::NUM_MON-1:0] monitor_event,
   // interrupt
   output logic irq
);
   import pm_throttle_pkg::*;

   localparam int MS_W = $clog2(MS_CYCLES);
   localparam int US_W = $clog2(US_TICK_CYCLES);
   localparam int SLOT_W = $clog2(SLOT_CYCLES);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wait_req;
      logic [31:0] rdata;
      logic [31:0] counts;
      logic [31:0] gpi;
      logic thr_en;
      logic [IRQ_W-1:0] status;
      logic [IRQ_W-1:0] mask;
      logic irq;
      logic [US_W-1:0] us_cnt;
      logic [MS_W-1:0] ms_cnt;
      logic [SLOT_W-1:0] slot_cnt;
      logic [DUTY_W-1:0] phase;
      logic stop_n;
      logic sleep;
      logic thr_prev;
      fb_mode_type fb_mode;
      logic [FB_W-1:0] fast_burst_count;
      logic fb_expired;
      logic lock_done;
   } ctl_state_type;

   ctl_state_type r, n;
   gpi_cfg_if cfg ();

   logic us_tick;
   logic ms_tick;
   logic slot_end;
   logic lock_tick;
   logic thr_act;
   logic [DUTY_W-1:0] duty;
   logic [FB_W-1:0] lock_count;
   logic [FB_W-1:0] burst_count;
   logic [31:0] wmask;
   logic [IRQ_W-1:0] clr;
   logic [IRQ_W-1:0] set;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{be[b]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [31:0] m,
      input logic [31:0] keep);
      return ((old & ~m) | (wd & m)) & keep;
   endfunction

   function automatic logic [31:0] read_mux(input logic [7:0] a,
      input ctl_state_type s);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         COUNTS_OFF: d = s.counts;
         GPI_CTL_OFF: d = s.gpi;
         IRQ_STATUS_OFF: d[IRQ_W-1:0] = s.status;
         IRQ_MASK_OFF: d[IRQ_W-1:0] = s.mask;
         CTRL_OFF: d[CTRL_THR_EN_BIT] = s.thr_en;
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ---------------------------------------------------------------
   // decoded fields and rate enables
   // ---------------------------------------------------------------
   assign duty = r.counts[DUTY_LSB +: DUTY_W];
   assign lock_count = r.counts[LOCK_CNT_LSB +: FB_W];
   assign burst_count = r.counts[FAST_BURST_COUNT_LSB +: FB_W];
   assign us_tick = r.us_cnt == US_W'(US_TICK_CYCLES - 1);
   assign ms_tick = r.ms_cnt == MS_W'(MS_CYCLES - 1);
   assign slot_end = r.slot_cnt == SLOT_W'(SLOT_CYCLES - 1);
   assign lock_tick = r.counts[LOCK_SEL_BIT] ? us_tick : ms_tick;
   assign thr_act = r.thr_en & ~thermal_alarm_in_n;
   assign wmask = be_mask(avs_byteenable);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      n = r;
      clr = '0;
      set = '0;
      n.fb_expired = 1'b0;
      n.lock_done = 1'b0;
      n.us_cnt = us_tick ? '0 : r.us_cnt + 1'b1;
      n.ms_cnt = ms_tick ? '0 : r.ms_cnt + 1'b1;

      // one wait state; a write lands one edge after waitrequest drops, where it is sampled low
      n.wait_req = 1'b1;
      if ((avs_read || avs_write) && r.wait_req) begin
         n.wait_req = 1'b0;
         if (avs_read) begin
            n.rdata = read_mux(avs_address, r);
         end
      end else if (avs_write && !r.wait_req) begin
         case (avs_address)
            COUNTS_OFF: n.counts = merge(r.counts, avs_writedata, wmask,
               COUNTS_MASK);
            GPI_CTL_OFF: n.gpi = merge(r.gpi, avs_writedata, wmask,
               GPI_MASK);
            IRQ_STATUS_OFF: clr = avs_writedata[IRQ_W-1:0] &
               wmask[IRQ_W-1:0];
            IRQ_MASK_OFF: n.mask = (r.mask & ~wmask[IRQ_W-1:0]) |
               (avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
            CTRL_OFF: begin
               if (wmask[CTRL_THR_EN_BIT]) begin
                  n.thr_en = avs_writedata[CTRL_THR_EN_BIT];
               end
            end
            default: ;
         endcase
      end

      // throttle: eight slots per period, duty code slots held stopped
      n.thr_prev = thr_act;
      if (!thr_act) begin
         n.slot_cnt = '0;
         n.phase = '0;
         n.stop_n = 1'b1;
      end else begin
         n.slot_cnt = slot_end ? '0 : r.slot_cnt + 1'b1;
         if (slot_end) begin
            n.phase = r.phase + 1'b1;
         end
         // code 000 leaves the clock running; no defined duty for it
         n.stop_n = !(r.phase < duty);
      end

      // cache sleep follows the stopped slots while throttling
      n.sleep = r.counts[SLEEP_EN_BIT] & clock_ctl_mode &
         (thr_act ? !n.stop_n : 1'b1);

      // fast burst timer
      case (r.fb_mode)
         FB_LOCK: begin
            if (lock_tick) begin
               if (r.fast_burst_count == '0) begin
                  n.lock_done = 1'b1;
                  n.fb_mode = FB_IDLE;
               end else begin
                  n.fast_burst_count = r.fast_burst_count - 1'b1;
               end
            end
         end
         FB_BURST: begin
            if (ms_tick) begin
               if (r.fast_burst_count == '0) begin
                  n.fb_expired = 1'b1;
                  n.fast_burst_count = burst_count;
               end else begin
                  n.fast_burst_count = r.fast_burst_count - 1'b1;
               end
            end
         end
         FB_IDLE: ;
         default: n.fb_mode = FB_IDLE;
      endcase
      if (burst_start) begin
         n.fb_mode = FB_BURST;
         n.fast_burst_count = burst_count;
      end
      // lock measurement has priority over a burst restart
      if (cpu_wake) begin
         n.fb_mode = FB_LOCK;
         n.fast_burst_count = lock_count;
      end

      // sticky status, set wins over a clear in the same cycle
      set[IRQ_LOCK] = n.lock_done;
      set[IRQ_BURST] = n.fb_expired;
      set[IRQ_MON] = |cfg.event_out;
      set[IRQ_THERM] = thr_act & ~r.thr_prev;
      n.status = (r.status & ~clr) | set;
      n.irq = |(n.status & n.mask);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.wait_req <= 1'b1;
         r.stop_n <= 1'b1;
         r.counts <= REG_RST;
         r.gpi <= REG_RST;
      end else begin
         r <= n;
      end
   end

   // ---------------------------------------------------------------
   // monitor conditioning and outputs
   // ---------------------------------------------------------------
   assign cfg.enable = r.gpi[EN_LSB +: NUM_MON];
   assign cfg.polarity = r.gpi[POL_LSB +: NUM_MON];
   assign cfg.edge_sel = r.gpi[EDGE_LSB +: NUM_EDGE];

   gpi_monitor_cond u_mon (
      .clk(clk),
      .sys_rst(sys_rst),
      .general_input_pin(general_input_pin),
      .cfg(cfg.mon)
   );

   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.wait_req;
   assign cpu_stop_clock_n = r.stop_n;
   assign cache_sleep_out = r.sleep;
   assign fb_expired = r.fb_expired;
   assign pll_lock_done = r.lock_done;
   assign monitor_event = cfg.event_out;
   assign irq = r.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   stop_duty_a: assert property (!cpu_stop_clock_n |->
      $past(thr_act) && ($past(r.phase) < $past(duty)))
      else $error("stop clock asserted outside duty slots");
   stop_release_a: assert property (!thr_act |=> cpu_stop_clock_n)
      else $error("stop clock asserted without throttling");
   full_period_a: assert property (thr_act && $past(thr_act) &&
      r.phase == 3'h0 && duty == 3'h4 |=> !cpu_stop_clock_n)
      else $error("duty slot zero not stopped");
   lock_load_a: assert property (cpu_wake |=>
      r.fb_mode == FB_LOCK && r.fast_burst_count == $past(lock_count))
      else $error("lock count not loaded on wake");
   lock_rate_a: assert property (r.fb_mode == FB_LOCK &&
      $past(r.fb_mode) == FB_LOCK && !$past(cpu_wake) &&
      r.fast_burst_count != $past(r.fast_burst_count) |-> $past(lock_tick))
      else $error("lock timer moved off its tick");
   burst_load_a: assert property (burst_start && !cpu_wake |=>
      r.fb_mode == FB_BURST && r.fast_burst_count == $past(burst_count))
      else $error("burst count not loaded");
   burst_reload_a: assert property (fb_expired |->
      r.fast_burst_count == $past(burst_count) || $past(burst_start || cpu_wake))
      else $error("burst timer not reloaded at expiry");
   sleep_gate_a: assert property (cache_sleep_out |->
      $past(r.counts[SLEEP_EN_BIT]) && $past(clock_ctl_mode))
      else $error("cache sleep driven while disabled");
   status_set_a: assert property (fb_expired |-> r.status[IRQ_BURST])
      else $error("burst expiry lost from status");
   irq_level_a: assert property (irq == |(r.status & r.mask))
      else $error("interrupt not equal to masked status");
   bus_answer_a: assert property ((avs_read || avs_write) &&
      avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   expiry_pulse_a: assert property (fb_expired |=> !fb_expired)
      else $error("burst expiry longer than one cycle");
   lock_pulse_a: assert property (pll_lock_done |=> !pll_lock_done)
      else $error("lock done longer than one cycle");

   // ---------------------------------------------------------------
   // bus and interrupt checks
   // ---------------------------------------------------------------
   wait_high_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   ctrl_write_a: assert property (avs_write && !avs_waitrequest &&
      avs_address == CTRL_OFF && avs_byteenable[0] |=>
      r.thr_en == $past(avs_writedata[CTRL_THR_EN_BIT]))
      else $error("control write did not land");
   rd_ctrl_a: assert property (avs_read && avs_waitrequest &&
      avs_address == CTRL_OFF |=> avs_readdata == 32'($past(r.thr_en)))
      else $error("control read data wrong");
   w1c_clear_a: assert property (avs_write && !avs_waitrequest &&
      avs_address == IRQ_STATUS_OFF && avs_byteenable[0] &&
      avs_writedata[IRQ_LOCK] |=> !r.status[IRQ_LOCK] || pll_lock_done)
      else $error("lock status not cleared by a one");
   // only a status clear or a mask write may drop a raised interrupt
   irq_hold_a: assert property (irq && !(avs_write && !avs_waitrequest &&
      (avs_address == IRQ_STATUS_OFF || avs_address == IRQ_MASK_OFF))
      |=> irq)
      else $error("interrupt dropped without a status or mask write");

   throttle_c: cover property (!cpu_stop_clock_n ##1 cpu_stop_clock_n);
   lock_done_c: cover property (cpu_wake ##[1:200] pll_lock_done);
   irq_c: cover property (irq);
   sleep_c: cover property (cache_sleep_out);
endmodule // pm_throttle_ctl
`default_nettype wire

// *** design/pm_throttle_pkg.sv ***
`default_nettype none
package pm_throttle_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] COUNTS_OFF = 8'h48;
   localparam logic [7:0] GPI_CTL_OFF = 8'h4C;
   localparam logic [7:0] IRQ_STATUS_OFF = 8'h50;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h54;
   localparam logic [7:0] CTRL_OFF = 8'h58;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // ---------------------------------------------------------------
   // throttle and burst counts fields
   // ---------------------------------------------------------------
   localparam int FAST_BURST_COUNT_LSB = 0;
   localparam int FB_W = 5;
   localparam int LOCK_SEL_BIT = 5;
   localparam int LOCK_CNT_LSB = 6;
   localparam int DUTY_LSB = 11;
   localparam int DUTY_W = 3;
   localparam int SLEEP_EN_BIT = 14;
   localparam logic [31:0] COUNTS_MASK = 32'h0000_7FFF;
   // ---------------------------------------------------------------
   // gpi input control fields
   // ---------------------------------------------------------------
   localparam int NUM_MON = 13;
   localparam int NUM_EDGE = 2;
   localparam int EN_LSB = 0;
   localparam int POL_LSB = 13;
   localparam int EDGE_LSB = 26;
   localparam logic [31:0] GPI_MASK = 32'h0FFF_FFFF;
   localparam int NUM_PINS = 22;
   // entry k is the pin index feeding monitor k+1
   localparam logic [12:0][4:0] MON_PIN_MAP = {
      5'h15, 5'h14, 5'h13, 5'h12, 5'h04, 5'h11, 5'h10,
      5'h0F, 5'h0E, 5'h0D, 5'h00, 5'h06, 5'h05};
   // ---------------------------------------------------------------
   // interrupt status bits and control bits
   // ---------------------------------------------------------------
   localparam int IRQ_W = 4;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_BURST = 1;
   localparam int IRQ_MON = 2;
   localparam int IRQ_THERM = 3;
   localparam int CTRL_THR_EN_BIT = 0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int LOCK_FINE_US = 1;
   localparam int LOCK_COARSE_MS = 1;
   localparam int THROTTLE_SLOT_US = 100;
   localparam int US_TICK_CYCLES = (CLK_HZ / 1_000_000) * LOCK_FINE_US;
   localparam int MS_TICK_CYCLES = (CLK_HZ / 1_000) * LOCK_COARSE_MS;
   localparam int SLOT_CYCLES = (CLK_HZ / 1_000_000) * THROTTLE_SLOT_US;
   typedef enum logic [1:0] {FB_IDLE, FB_BURST, FB_LOCK} fb_mode_type;
endpackage
`default_nettype wire

// *** tb/cpu_clock_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// processor clock control side: wakes after a chosen lag
// ---------------------------------------------------------------
module cpu_clock_model (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bench command
   input wire logic wake_req,
   input wire logic [3:0] wake_lag,
   // processor status
   output logic cpu_wake
);
   logic pend_q;
   logic [3:0] cnt_q;
   // lag of zero answers promptly, up to 15 cycles answers slowly
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_q <= 1'b0;
         cnt_q <= 4'h0;
         cpu_wake <= 1'b0;
      end else begin
         cpu_wake <= 1'b0;
         if (wake_req) begin
            pend_q <= 1'b1;
            cnt_q <= wake_lag;
         end else if (pend_q) begin
            if (cnt_q == 4'h0) begin
               cpu_wake <= 1'b1;
               pend_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 4'h1;
            end
         end
      end
   end
endmodule // cpu_clock_model
`default_nettype wire

// *** tb/pm_throttle_and_gpi_monitor_ctl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pm_throttle_and_gpi_monitor_ctl_tb;
   import pm_throttle_pkg::*;
   localparam int MSC = 40;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic alarm_n = 1'b1;
   logic wake_req = 1'b0;
   logic [3:0] wake_lag = 4'h0;
   logic burst_start = 1'b0;
   logic ctl_mode = 1'b0;
   logic [21:0] pins = 22'h00_0000;
   logic cpu_wake, stop_n, sleep, fb_exp, lock_done, irq;
   logic [12:0] mon_ev, qn, qp, e_new, e_old;
   logic [31:0] seed = 32'h515a_305b;
   logic [31:0] q, cfg;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;
   int n, t;
   int pmap [13] = '{5, 6, 0, 13, 14, 15, 16, 17, 4, 18, 19, 20, 21};
   always #25 clk = ~clk;
   pm_throttle_ctl #(.MS_CYCLES(MSC)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .thermal_alarm_in_n(alarm_n), .cpu_wake(cpu_wake),
      .burst_start(burst_start), .clock_ctl_mode(ctl_mode),
      .cpu_stop_clock_n(stop_n), .cache_sleep_out(sleep),
      .fb_expired(fb_exp), .pll_lock_done(lock_done),
      .general_input_pin(pins), .monitor_event(mon_ev), .irq(irq));
   cpu_clock_model i_cpu (.clk(clk), .sys_rst(sys_rst), .wake_req(wake_req),
      .wake_lag(wake_lag), .cpu_wake(cpu_wake));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic [12:0] qual(input logic [21:0] p,
      input logic [31:0] c);
      for (int k = 0; k < 13; k++) begin
         qual[k] = c[k] & (p[pmap[k]] ^ c[13+k]);
      end
   endfunction
   task automatic test_done();
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         fails++;
      end
   endtask
   // one access; the request stands until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // a hang here is ended by the cycle watchdog
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // counts edges until s is sampled at level v
   task automatic wait_for(ref logic s, input logic v, input int lim,
      output int m);
      m = 0;
      do begin
         @(posedge clk);
         m++;
      end while (s !== v && m < lim);
   endtask
   task automatic wake(input logic [3:0] lag);
      wake_lag <= lag;
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      wait_for(cpu_wake, 1'b1, 40, n);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         fails++;
         test_done();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (pmap[k]) begin
         if (k < 6) begin
            bus(1'b0, 8'h48 + 8'(k * 4), 32'h0000_0000);
            chk(q, 32'h0000_0000);
         end
      end
      bus(1'b1, 8'h60, 32'hFFFF_FFFF);
      bus(1'b0, 8'h60, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      seed = xs(seed);
      bus(1'b1, GPI_CTL_OFF, seed);
      bus(1'b0, GPI_CTL_OFF, 32'h0000_0000);
      chk(q, seed & GPI_MASK);
      seed = xs(seed);
      bus(1'b1, COUNTS_OFF, seed);
      bus(1'b0, COUNTS_OFF, 32'h0000_0000);
      chk(q, seed & COUNTS_MASK);
      // first round all enabled, low active, edge mode; second all off
      for (int r = 0; r < 5; r++) begin
         seed = xs(seed);
         cfg = (r == 0) ? 32'h0FFF_FFFF : (r == 1) ? 32'h0000_0000 : seed;
         bus(1'b1, GPI_CTL_OFF, cfg);
         for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (i > 3)
               chk(32'(mon_ev), 32'(e_old));
            e_old = e_new;
            seed = xs(seed);
            qn = qual(seed[21:0], cfg);
            e_new = qn;
            if (cfg[26])
               e_new[11] = qn[11] & ~qp[11];
            if (cfg[27])
               e_new[12] = qn[12] & ~qp[12];
            qp = qn;
            pins <= seed[21:0];
         end
      end
      bus(1'b1, GPI_CTL_OFF, 32'h0000_0000);
      for (int b = 0; b < 3; b++) begin
         seed = xs(seed);
         t = (b == 0) ? 0 : (b == 1) ? 31 : int'(seed[4:0]);
         bus(1'b1, COUNTS_OFF, 32'(t));
         burst_start <= 1'b1;
         @(posedge clk);
         burst_start <= 1'b0;
         wait_for(fb_exp, 1'b1, 2000, n);
         wait_for(fb_exp, 1'b1, 2000, n);
         chk(32'(n), 32'((t + 1) * MSC));
      end
      for (int s = 0; s < 2; s++) begin
         seed = xs(seed);
         bus(1'b1, COUNTS_OFF, (32'(seed[10:6]) << 6) | (32'(s) << 5));
         wake(seed[3:0]);
         wait_for(lock_done, 1'b1, 3000, n);
         // the fine tick is 20 cycles of the 20 MHz clock
         t = s ? 20 : MSC;
         chk(32'(n >= int'(seed[10:6]) * t &&
            n <= (int'(seed[10:6]) + 1) * t + 4), 32'h1);
      end
      bus(1'b1, CTRL_OFF, 32'h0000_0001);
      ctl_mode <= 1'b1;
      for (int d = 1; d < 8; d++) begin
         bus(1'b1, COUNTS_OFF, (32'(d) << 11) | 32'h0000_4000);
         alarm_n <= 1'b0;
         wait_for(stop_n, 1'b0, 20, n);
         chk(32'(n), 32'h2);
         repeat (10) @(posedge clk);
         chk(32'(sleep), 32'h1);
         wait_for(stop_n, 1'b1, 20000, n);
         chk(32'(n + 10), 32'(d * 2000));
         repeat (10) @(posedge clk);
         chk(32'(sleep), 32'h0);
         if (d == 7) begin
            wait_for(stop_n, 1'b0, 20000, n);
            chk(32'(n + 10), 32'd2000);
         end
         alarm_n <= 1'b1;
         repeat (3) @(posedge clk);
         chk(32'(stop_n), 32'h1);
      end
      bus(1'b1, COUNTS_OFF, 32'h0000_4800);
      repeat (3) @(posedge clk);
      chk(32'(sleep), 32'h1);
      bus(1'b1, COUNTS_OFF, 32'h0000_0800);
      repeat (3) @(posedge clk);
      chk(32'(sleep), 32'h0);
      bus(1'b1, CTRL_OFF, 32'h0000_0000);
      ctl_mode <= 1'b0;
      bus(1'b1, IRQ_MASK_OFF, 32'h0000_000F);
      bus(1'b1, IRQ_STATUS_OFF, 32'h0000_000F);
      bus(1'b0, IRQ_STATUS_OFF, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk(32'(irq), 32'h0);
      bus(1'b1, IRQ_MASK_OFF, 32'h0000_0001);
      bus(1'b1, COUNTS_OFF, 32'h0000_0060);
      wake(4'h0);
      wait_for(lock_done, 1'b1, 200, n);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      bus(1'b0, IRQ_STATUS_OFF, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      bus(1'b1, IRQ_MASK_OFF, 32'h0000_0000);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      bus(1'b1, IRQ_STATUS_OFF, 32'h0000_0001);
      bus(1'b0, IRQ_STATUS_OFF, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      // a second reset in mid-run must clear the control fields again
      bus(1'b1, GPI_CTL_OFF, 32'h0000_1FFF);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      bus(1'b0, GPI_CTL_OFF, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      test_done();
   end
endmodule // pm_throttle_and_gpi_monitor_ctl_tb
`default_nettype wire
